// ### hw/bfs_pkg.sv
package bfs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] BFS_FUSE_STATUS_OFS = 12'h000;
  localparam logic [11:0] BFS_BOOT_CTRL_OFS   = 12'h004;
  localparam logic [11:0] BFS_BOOT_STAT_OFS   = 12'h008;

  // ----------------------------------------------------------------
  // fuse word field positions
  // ----------------------------------------------------------------
  localparam int BFS_CSEL_LSB       = 23;
  localparam int BFS_DBG_ACCESS_BIT = 22;
  localparam int BFS_LOCK_JTAG_BIT  = 21;
  localparam int BFS_LOCK_DAP_BIT   = 20;
  localparam int BFS_LOCK_CPU0_BIT  = 19;
  localparam int BFS_LOCK_CPU1_BIT  = 18;
  localparam int BFS_LOCK_TRACE_BIT = 17;
  localparam int BFS_LOCK_FPGA_BIT  = 16;
  localparam int BFS_CLR_ORDER_BIT  = 11;
  localparam int BFS_CLR_COLD_BIT   = 10;
  localparam int BFS_CLR_WARM_BIT   = 9;
  localparam int BFS_OC_FORBID_BIT  = 8;
  localparam int BFS_CLK_SEL_BIT    = 7;
  localparam int BFS_FABRIC_BIT     = 6;
  localparam int BFS_AES_BIT        = 5;
  localparam int BFS_KAK_SRC_LSB    = 2;
  localparam int BFS_KAK_LEN_BIT    = 1;
  localparam int BFS_AUTH_BIT       = 0;

  // implemented bits of the fuse word; reserved 31:27 and 15:12 read as zero
  localparam logic [31:0] BFS_FUSE_MASK   = 32'h07FF_0FFF;
  localparam logic [31:0] BFS_FUSE_RESET  = 32'h0000_0000;
  localparam logic [2:0]  BFS_BOOT_SELECT_PINS_FABRIC = 3'h1;
  localparam logic [1:0]  BFS_HTRANS_NSEQ = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BFS_ST_WAIT = 2'b00,
    BFS_ST_LOAD = 2'b01,
    BFS_ST_DONE = 2'b10
  } bfs_state_e;

  // decoded boot policy handed to the rest of the system
  typedef struct packed {
    logic [3:0] clk_sel_fuses;
    logic       dbg_access_init;
    logic [5:0] dbg_locks;
    logic       ram_clr_serial;
    logic       ram_clr_cold;
    logic       ram_clr_warm;
    logic       onchip_ram_boot_forbid;
    logic       boot_clk_internal;
    logic       boot_from_fabric;
    logic       force_decrypt;
    logic [2:0] kak_source;
    logic       kak_len_384;
    logic       auth_required;
  } bfs_policy_s;

endpackage : bfs_pkg

// ### hw/bfs_fuse_status.sv
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - capture fuse word from the configuration subsystem after power-up, present to firmware
// - bits 31:27 and 15:12 are reserved, read here as zero
// - bits 26:23 report the four clock select fuses
// - bit 22 reports initial state of debug access domains
// - bit 21 locks boundary-scan debug level; 1 blocks software changes
// - bit 20 locks debug access port level; 1 blocks software changes
// - bit 19 locks core zero debug level; 1 blocks software changes
// - bit 18 locks core one debug level; 1 blocks software changes
// - bit 17 locks trace and debug infrastructure level when 1
// - bit 16 locks fabric debug access level when 1
// - bit 11: tamper RAM clear 0 parallel, 1 serial
// - bit 10 set means clear all RAMs on cold reset
// - bit 9 set means clear all RAMs on warm reset
// - bit 8 set forbids second-stage boot from on-chip RAM
// - bit 7 boot clock: 0 external oscillator, 1 internal low-speed
// - bit 6 set forces fabric-only boot, ignoring pins and clock select
// - bit 5 set always decrypts image, else header decides
// - bits 4:2 report key authorization key source
// - bit 1 key length: 0 means 256 bits, 1 means 384 bits
// - bit 0 set requires authentication of every flash image
// - boot select pins value 0x1 picks fabric for that boot only
module bfs_fuse_status
  import bfs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        por_capture,
  input  wire logic [31:0] sensed_fuses,
  input  wire logic [2:0]  boot_select_pins,
  input  wire logic        boot_sample,
  input  wire logic        onchip_boot_enable,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output bfs_policy_s      policy,
  output logic             fuses_valid,
  output logic             boot_from_fabric,
  output logic             onchip_boot_allowed,
  output logic             clk_sel_ignored,
  output logic             dbg_write_enable_jtag,
  output logic             dbg_write_enable_dap,
  output logic             dbg_write_enable_cpu0,
  output logic             dbg_write_enable_cpu1,
  output logic             dbg_write_enable_trace,
  output logic             dbg_write_enable_fpga
);

  // ----------------------------------------------------------------
  // fuse capture
  // ----------------------------------------------------------------
  bfs_state_e  state_q;
  logic [31:0] fuse_q;
  logic [2:0]  boot_select_pins_q;
  logic        boot_select_pins_valid_q;
  logic        ctrl_q;
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic        rd_pend_q;
  logic [11:0] rd_addr_q;
  logic [31:0] rd_word;

  // one capture per power-up; the word is then frozen until hresetn drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= BFS_ST_WAIT;
    end else begin
      unique case (state_q)
        BFS_ST_WAIT: if (por_capture) state_q <= BFS_ST_LOAD;
        BFS_ST_LOAD: state_q <= BFS_ST_DONE;
        BFS_ST_DONE: state_q <= BFS_ST_DONE;
        default:     state_q <= BFS_ST_WAIT;
      endcase
    end
  end

  // only the capture loads the word; bus writes never reach it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_q <= BFS_FUSE_RESET;
    end else if (state_q == BFS_ST_LOAD) begin
      fuse_q <= sensed_fuses & BFS_FUSE_MASK;
    end
  end

  // boot select pins are sampled per boot, so a fabric pick lasts one boot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_select_pins_q       <= 3'h0;
      boot_select_pins_valid_q <= 1'b0;
    end else if (boot_sample) begin
      boot_select_pins_q       <= boot_select_pins;
      boot_select_pins_valid_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // decoded policy
  // ----------------------------------------------------------------
  // field extraction; positions come from the package
  always_comb begin
    policy.clk_sel_fuses          = fuse_q[BFS_CSEL_LSB +: 4];
    policy.dbg_access_init        = fuse_q[BFS_DBG_ACCESS_BIT];
    policy.dbg_locks              = fuse_q[BFS_LOCK_FPGA_BIT +: 6];
    policy.ram_clr_serial         = fuse_q[BFS_CLR_ORDER_BIT];
    policy.ram_clr_cold           = fuse_q[BFS_CLR_COLD_BIT];
    policy.ram_clr_warm           = fuse_q[BFS_CLR_WARM_BIT];
    policy.onchip_ram_boot_forbid = fuse_q[BFS_OC_FORBID_BIT];
    policy.boot_clk_internal      = fuse_q[BFS_CLK_SEL_BIT];
    policy.boot_from_fabric       = fuse_q[BFS_FABRIC_BIT];
    policy.force_decrypt          = fuse_q[BFS_AES_BIT];
    policy.kak_source             = fuse_q[BFS_KAK_SRC_LSB +: 3];
    policy.kak_len_384            = fuse_q[BFS_KAK_LEN_BIT];
    policy.auth_required          = fuse_q[BFS_AUTH_BIT];
  end

  // a lock bit of 1 removes software's right to change that debug level
  assign dbg_write_enable_jtag  = fuses_valid & ~fuse_q[BFS_LOCK_JTAG_BIT];
  assign dbg_write_enable_dap   = fuses_valid & ~fuse_q[BFS_LOCK_DAP_BIT];
  assign dbg_write_enable_cpu0  = fuses_valid & ~fuse_q[BFS_LOCK_CPU0_BIT];
  assign dbg_write_enable_cpu1  = fuses_valid & ~fuse_q[BFS_LOCK_CPU1_BIT];
  assign dbg_write_enable_trace = fuses_valid & ~fuse_q[BFS_LOCK_TRACE_BIT];
  assign dbg_write_enable_fpga  = fuses_valid & ~fuse_q[BFS_LOCK_FPGA_BIT];

  assign fuses_valid = (state_q == BFS_ST_DONE);

  // fuse wins over pins; pins only matter once sampled for this boot
  assign boot_from_fabric = fuse_q[BFS_FABRIC_BIT] |
                            (boot_select_pins_valid_q & (boot_select_pins_q == BFS_BOOT_SELECT_PINS_FABRIC));
  assign clk_sel_ignored  = boot_from_fabric;

  // on-chip boot needs both the fuse clear and the system enable
  assign onchip_boot_allowed = fuses_valid & ~fuse_q[BFS_OC_FORBID_BIT] &
                               onchip_boot_enable;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture; only ctrl is writable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rd_addr_q <= 12'h000;
    end else if (hready) begin
      wr_pend_q <= hsel & (htrans == BFS_HTRANS_NSEQ) & hwrite;
      rd_pend_q <= hsel & (htrans == BFS_HTRANS_NSEQ) & ~hwrite;
      wr_addr_q <= haddr[11:0];
      rd_addr_q <= haddr[11:0];
    end
  end

  // scratch control bit; a write to the fuse word is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 1'b0;
    end else if (wr_pend_q && wr_addr_q == BFS_BOOT_CTRL_OFS) begin
      ctrl_q <= hwdata[0];
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_addr_q)
      BFS_FUSE_STATUS_OFS: rd_word = fuse_q;
      BFS_BOOT_CTRL_OFS:   rd_word = {31'h0000_0000, ctrl_q};
      BFS_BOOT_STAT_OFS:   rd_word = {26'h000_0000, boot_select_pins_q, onchip_boot_allowed,
                                      boot_from_fabric, fuses_valid};
      default:             rd_word = 32'h0000_0000;
    endcase
  end

  // data only stands in a read data phase, so idle cycles show zero
  assign hrdata = rd_pend_q ? rd_word : 32'h0000_0000;

endmodule : bfs_fuse_status

// ### sim/bfs_fuse_status_monitor.sv
`timescale 1ns/1ps
module bfs_fuse_status_monitor
  import bfs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        por_capture,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire bfs_policy_s policy,
  input wire logic        fuses_valid,
  input wire logic        boot_from_fabric,
  input wire logic        clk_sel_ignored,
  input wire logic        onchip_boot_allowed,
  input wire logic        dbg_write_enable_jtag,
  input wire logic        dbg_write_enable_fpga
);
  // ----------------------------------------------------------------
  // data phase tracking
  // ----------------------------------------------------------------
  logic rd_fuse_q;
  // set for the data phase of a fuse word read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_fuse_q <= 1'b0;
    else rd_fuse_q <= hsel && hready && htrans == BFS_HTRANS_NSEQ && !hwrite &&
                      haddr[11:0] == BFS_FUSE_STATUS_OFS;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_CAPTURE: assert property (por_capture && !fuses_valid |-> ##[1:2] fuses_valid)
    else $error("fuse word not captured");
  AST_RSVD: assert property (rd_fuse_q |-> (hrdata & ~BFS_FUSE_MASK) == 32'h0)
    else $error("reserved fuse bits set");
  AST_CSEL: assert property (rd_fuse_q |-> hrdata[26:23] == policy.clk_sel_fuses)
    else $error("clock select field mismatch");
  AST_HOLD: assert property (fuses_valid |=> fuses_valid && $stable(policy))
    else $error("captured fuses changed");
  AST_JTAG: assert property (dbg_write_enable_jtag == (fuses_valid && !policy.dbg_locks[5]))
    else $error("scan lock wrong");
  AST_FPGA: assert property (dbg_write_enable_fpga == (fuses_valid && !policy.dbg_locks[0]))
    else $error("fabric lock wrong");
  AST_FABRIC: assert property (fuses_valid && policy.boot_from_fabric |-> boot_from_fabric && clk_sel_ignored)
    else $error("fabric boot not forced");
  AST_ONCHIP: assert property (!fuses_valid || policy.onchip_ram_boot_forbid |-> !onchip_boot_allowed)
    else $error("on-chip boot allowed");
  AST_BUS: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  cover property (rd_fuse_q);
  cover property (fuses_valid && boot_from_fabric);
  cover property ($rose(fuses_valid));
endmodule : bfs_fuse_status_monitor

bind bfs_fuse_status bfs_fuse_status_monitor i_bfs_fuse_status_monitor (
  .hclk(hclk), .hresetn(hresetn), .por_capture(por_capture), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .policy(policy), .fuses_valid(fuses_valid), .boot_from_fabric(boot_from_fabric),
  .clk_sel_ignored(clk_sel_ignored), .onchip_boot_allowed(onchip_boot_allowed),
  .dbg_write_enable_jtag(dbg_write_enable_jtag), .dbg_write_enable_fpga(dbg_write_enable_fpga));

// ### sim/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module testbench
  import bfs_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, por_capture = 1'b0, boot_sample = 1'b0;
  logic        onchip_boot_enable = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdy_smp;
  logic [31:0] sensed_fuses = 32'h0, haddr = 32'h0, hwdata = 32'h0, hrdata, rd_smp;
  logic [2:0]  boot_select_pins = 3'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, fuses_valid, boot_from_fabric, onchip_boot_allowed;
  logic        clk_sel_ignored, dbg_write_enable_jtag, dbg_write_enable_dap;
  logic        dbg_write_enable_cpu0, dbg_write_enable_cpu1, dbg_write_enable_trace;
  logic        dbg_write_enable_fpga;
  bfs_policy_s policy;
  int          n_fail = 0, samples_checked = 0, cyc = 0;

  bfs_fuse_status i_bfs_fuse_status (.hclk(hclk), .hresetn(hresetn), .por_capture(por_capture),
    .sensed_fuses(sensed_fuses), .boot_select_pins(boot_select_pins), .boot_sample(boot_sample),
    .onchip_boot_enable(onchip_boot_enable), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .policy(policy), .fuses_valid(fuses_valid),
    .boot_from_fabric(boot_from_fabric), .onchip_boot_allowed(onchip_boot_allowed),
    .clk_sel_ignored(clk_sel_ignored), .dbg_write_enable_jtag(dbg_write_enable_jtag),
    .dbg_write_enable_dap(dbg_write_enable_dap), .dbg_write_enable_cpu0(dbg_write_enable_cpu0),
    .dbg_write_enable_cpu1(dbg_write_enable_cpu1),
    .dbg_write_enable_trace(dbg_write_enable_trace), .dbg_write_enable_fpga(dbg_write_enable_fpga));

  // 100 ns clock; bus answer sampled at the edge so reads never race the design
  always #50 hclk = ~hclk;
  always @(posedge hclk) begin
    rdy_smp <= hreadyout;
    rd_smp <= hrdata;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test;
    end
  end

  task automatic tick; @(posedge hclk); #1; endtask : tick

  task automatic ahb(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= BFS_HTRANS_NSEQ;
    haddr <= a;
    hwrite <= w;
    do tick; while (rdy_smp !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do tick; while (rdy_smp !== 1'b1);
    rd = rd_smp;
  endtask : ahb

  task automatic power_up(input logic [31:0] f);
    hresetn <= 1'b0;
    repeat (12) tick;
    hresetn <= 1'b1;
    sensed_fuses <= f;
    tick;
    `CHK(fuses_valid, 1'b0)
    por_capture <= 1'b1;
    tick;
    por_capture <= 1'b0;
    repeat (3) tick;
  endtask : power_up

  // read the word, try to overwrite it and to recapture it
  task automatic t_fuse(input logic [31:0] f);
    logic [31:0] rd;
    ahb(1'b0, 32'h0, 32'h0, rd);
    `CHK(rd[31:12], f[31:12] & BFS_FUSE_MASK[31:12])
    `CHK(rd[11:5], f[11:5])
    `CHK(rd[4:0], f[4:0])
    ahb(1'b1, 32'h0, ~f, rd);
    sensed_fuses <= ~f;
    por_capture <= 1'b1;
    tick;
    por_capture <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0, rd);
    `CHK(rd, f & BFS_FUSE_MASK)
    `CHK({dbg_write_enable_jtag, dbg_write_enable_dap, dbg_write_enable_cpu0}, ~f[21:19])
    `CHK({dbg_write_enable_cpu1, dbg_write_enable_trace, dbg_write_enable_fpga}, ~f[18:16])
  endtask : t_fuse

  // every pin code, with the system manager enable toggled
  task automatic t_boot(input logic [31:0] f);
    logic [31:0] rd;
    for (int i = 0; i < 8; i++) begin
      boot_select_pins <= 3'(i);
      boot_sample <= 1'b1;
      onchip_boot_enable <= i[0];
      tick;
      boot_sample <= 1'b0;
      repeat (2) tick;
      `CHK(boot_from_fabric, f[6] | (i == 1))
      `CHK(clk_sel_ignored, f[6] | (i == 1))
      `CHK(onchip_boot_allowed, ~f[8] & i[0])
      ahb(1'b0, 32'h8, 32'h0, rd);
      `CHK(rd[5:0], {3'(i), ~f[8] & i[0], f[6] | (i == 1), 1'b1})
    end
    ahb(1'b1, 32'h4, 32'h1, rd);
    ahb(1'b0, 32'h4, 32'h0, rd);
    `CHK(rd, 32'h1)
    ahb(1'b0, 32'hC, 32'h0, rd);
    `CHK(rd, 32'h0)
  endtask : t_boot

  task automatic end_of_test;
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // two complementary fuse words so every field is seen at 0 and 1
  initial begin
    for (int k = 0; k < 2; k++) begin
      power_up(k ? 32'h0555_0ABF : 32'hFAAA_F540);
      t_fuse(k ? 32'h0555_0ABF : 32'hFAAA_F540);
      t_boot(k ? 32'h0555_0ABF : 32'hFAAA_F540);
    end
    end_of_test;
  end
endmodule : testbench
